// ---- hw/hps_pkg.sv ----
package hps_pkg;

	// Register indices; byte address is four times the index
	localparam logic [5:0] IDX_CTRL   = 6'h1D;
	localparam logic [5:0] IDX_STATUS = 6'h1F;
	localparam logic [5:0] IDX_ISTAT  = 6'h20;
	localparam logic [5:0] IDX_IMASK  = 6'h21;

	localparam logic [7:0] ADDR_CTRL   = {IDX_CTRL, 2'b00};
	localparam logic [7:0] ADDR_STATUS = {IDX_STATUS, 2'b00};
	localparam logic [7:0] ADDR_ISTAT  = {IDX_ISTAT, 2'b00};
	localparam logic [7:0] ADDR_IMASK  = {IDX_IMASK, 2'b00};

	// Holdover control field positions
	localparam int CTRL_HOLD_EN_LO = 0;
	localparam int CTRL_EXT_HOLD   = 1;
	localparam int CTRL_HOLD_EN_HI = 2;
	localparam int CTRL_COMP_EN    = 3;
	localparam int CTRL_RB_DIS     = 4;
	localparam int CTRL_W          = 5;
	localparam logic [4:0] CTRL_RESET = 5'h00;

	// Status field positions
	localparam int ST_LOCK      = 0;
	localparam int ST_PRI_ABOVE = 1;
	localparam int ST_SEC_ABOVE = 2;
	localparam int ST_VCO_ABOVE = 3;
	localparam int ST_SEC_SEL   = 4;
	localparam int ST_HOLD_ACT  = 5;
	localparam int ST_CAL_DONE  = 6;
	localparam int ST_W         = 7;

	// Interrupt event positions
	localparam int IRQ_CAL_DONE   = 0;
	localparam int IRQ_HOLD_ENTER = 1;
	localparam int IRQ_LOCK_LOST  = 2;
	localparam int IRQ_REF_SWITCH = 3;
	localparam int IRQ_W          = 4;
	localparam logic [3:0] IRQ_RESET = 4'h0;

	// Pin multiplexer code for the comparator result
	localparam logic [4:0] PIN_SEL_COMP = 5'h1F;

	// Bus sequencing
	typedef enum logic {HPS_IDLE, HPS_ACCESS} hps_bus_state_t;

endpackage

// ---- hw/hps_sticky.sv ----
`timescale 1ns/1ns
module hps_sticky
(
	// Clock and reset
	input  wire logic pclk,
	input  wire logic presetn,
	// Event and clear
	input  wire logic set,
	input  wire logic clr,
	// Sticky bit
	output logic      q
);

	// Set beats clear so an event in the clear cycle survives
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			q <= 1'b0;
		else if (set)
			q <= 1'b1;
		else if (clr)
			q <= 1'b0;
	end

endmodule

// ---- hw/hps_regs.sv ----
`timescale 1ns/1ns
module hps_regs
	import hps_pkg::*;
(
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// Status inputs from the monitors and holdover engine
	input  wire logic        cal_finished,
	input  wire logic        holdover_active,
	input  wire logic        secondary_ref_selected,
	input  wire logic        vco_above_threshold,
	input  wire logic        secondary_ref_above,
	input  wire logic        primary_ref_above,
	input  wire logic        digital_lock_flag,
	// Lock indicator comparator raw result
	input  wire logic        lock_indicator_pin,
	// Monitor pin multiplexer selects
	input  wire logic [4:0]  status_pin_select,
	input  wire logic [4:0]  reference_monitor_select,
	// Controls to the holdover engine
	output logic             comparator_enable,
	output logic             lock_qualifier,
	output logic             automatic_holdover_enable,
	output logic             external_holdover_enable,
	// Monitor pin drive, active low comparator result
	output logic             status_pin_comp_n,
	output logic             status_pin_comp_valid,
	output logic             reference_monitor_comp_n,
	output logic             reference_monitor_comp_valid,
	// Interrupt
	output logic             irq
);

	hps_bus_state_t       state;
	logic [CTRL_W-1:0]    ctrl;
	logic [IRQ_W-1:0]     imask;
	logic [IRQ_W-1:0]     istat;
	logic [IRQ_W-1:0]     ev_set;
	logic [IRQ_W-1:0]     ev_clr;
	logic [ST_W-1:0]      live_status;
	logic                 cal_prev;
	logic                 hold_prev;
	logic                 lock_prev;
	logic                 sel_prev;
	logic                 armed;
	logic                 setup;
	logic                 done_wr;
	logic                 mapped;
	logic                 comp_result;
	logic                 hold_en;
	logic [31:0]          next_prdata;

	// Bus phase decode
	assign setup   = psel && !penable;
	assign done_wr = (state == HPS_ACCESS) && psel && penable && pready && pwrite;
	assign mapped  = (paddr == ADDR_CTRL) || (paddr == ADDR_STATUS) ||
	                 (paddr == ADDR_ISTAT) || (paddr == ADDR_IMASK);

	// Live 7-bit status field, sampled again on every read
	assign live_status = {cal_finished,
	                      holdover_active,
	                      secondary_ref_selected,
	                      vco_above_threshold,
	                      secondary_ref_above,
	                      primary_ref_above,
	                      digital_lock_flag};

	// Comparator powered only when enabled
	assign comp_result = ctrl[CTRL_COMP_EN] && lock_indicator_pin;
	assign hold_en     = ctrl[CTRL_HOLD_EN_HI] && ctrl[CTRL_HOLD_EN_LO];

	// Bus sequencer; one access cycle, no wait states
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			state <= HPS_IDLE;
		else
		begin
			unique case (state)
				HPS_IDLE:
					if (setup)
						state <= HPS_ACCESS;
				HPS_ACCESS:
					state <= (psel && !penable) ? HPS_ACCESS : HPS_IDLE;
			endcase
		end
	end

	// Ready and error are registered at the setup edge
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end
		else
		begin
			pready  <= setup;
			pslverr <= setup && !mapped;
		end
	end

	// Read data mux
	always_comb
	begin
		next_prdata = 32'h0000_0000;
		unique case (paddr)
			ADDR_CTRL:   next_prdata[CTRL_W-1:0] = ctrl;
			ADDR_STATUS: if (!ctrl[CTRL_RB_DIS])
				next_prdata[ST_W-1:0] = live_status;
			ADDR_ISTAT:  next_prdata[IRQ_W-1:0] = istat;
			ADDR_IMASK:  next_prdata[IRQ_W-1:0] = imask;
			default:     next_prdata = 32'h0000_0000;
		endcase
	end

	// Read data captured at the setup edge, held through access
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= 32'h0000_0000;
		else if (setup && !pwrite)
			prdata <= next_prdata;
	end

	// Holdover control; status offset has no write path
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			ctrl <= CTRL_RESET;
		else if (done_wr && paddr == ADDR_CTRL)
			ctrl <= pwdata[CTRL_W-1:0];
	end

	// Interrupt mask
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			imask <= IRQ_RESET;
		else if (done_wr && paddr == ADDR_IMASK)
			imask <= pwdata[IRQ_W-1:0];
	end

	// Previous inputs for edge events; armed once one history sample exists
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cal_prev  <= 1'b0;
			hold_prev <= 1'b0;
			lock_prev <= 1'b0;
			sel_prev  <= 1'b0;
			armed     <= 1'b0;
		end
		else
		begin
			cal_prev  <= cal_finished;
			hold_prev <= holdover_active;
			lock_prev <= digital_lock_flag;
			sel_prev  <= secondary_ref_selected;
			armed     <= 1'b1;
		end
	end

	// Event detection; history is unknown right after reset, so no false edges then
	assign ev_set[IRQ_CAL_DONE]   = armed && cal_finished && !cal_prev;
	assign ev_set[IRQ_HOLD_ENTER] = armed && holdover_active && !hold_prev;
	assign ev_set[IRQ_LOCK_LOST]  = armed && !digital_lock_flag && lock_prev;
	assign ev_set[IRQ_REF_SWITCH] = armed && (secondary_ref_selected != sel_prev);
	assign ev_clr = (done_wr && paddr == ADDR_ISTAT) ? pwdata[IRQ_W-1:0] : IRQ_RESET;

	// One sticky cell per event
	genvar gi;
	generate
		for (gi = 0; gi < IRQ_W; gi++)
		begin : g_evt
			hps_sticky u_sticky
			(
				.pclk    (pclk),
				.presetn (presetn),
				.set     (ev_set[gi]),
				.clr     (ev_clr[gi]),
				.q       (istat[gi])
			);
		end
	endgenerate

	// Level interrupt from unmasked sticky bits
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			irq <= 1'b0;
		else
			irq <= |(istat & imask);
	end

	// Holdover engine controls, registered for clean outputs
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			comparator_enable         <= 1'b0;
			lock_qualifier            <= 1'b1;
			automatic_holdover_enable <= 1'b0;
			external_holdover_enable  <= 1'b0;
		end
		else
		begin
			comparator_enable         <= ctrl[CTRL_COMP_EN];
			// Disabled comparator reads as true so automatic entry is not blocked
			lock_qualifier            <= ctrl[CTRL_COMP_EN] ? lock_indicator_pin : 1'b1;
			automatic_holdover_enable <= hold_en && !ctrl[CTRL_EXT_HOLD];
			external_holdover_enable  <= hold_en && ctrl[CTRL_EXT_HOLD];
		end
	end

	// Monitor pins; valid only on the comparator select code
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			status_pin_comp_n            <= 1'b1;
			status_pin_comp_valid        <= 1'b0;
			reference_monitor_comp_n     <= 1'b1;
			reference_monitor_comp_valid <= 1'b0;
		end
		else
		begin
			status_pin_comp_n            <= !comp_result;
			status_pin_comp_valid        <= status_pin_select == PIN_SEL_COMP;
			reference_monitor_comp_n     <= !comp_result;
			reference_monitor_comp_valid <= reference_monitor_select == PIN_SEL_COMP;
		end
	end

	// Comparator gating reaches the controller one cycle on
	a_comp_off_high: assert property (@(posedge pclk) disable iff (!presetn)
		!ctrl[CTRL_COMP_EN] |=> lock_qualifier && !comparator_enable)
		else $error("lock qualifier low with comparator off");

	a_comp_on_pin: assert property (@(posedge pclk) disable iff (!presetn)
		ctrl[CTRL_COMP_EN] |=> lock_qualifier == $past(lock_indicator_pin))
		else $error("lock qualifier does not follow pin");

	a_hold_both_bits: assert property (@(posedge pclk) disable iff (!presetn)
		##1 (automatic_holdover_enable || external_holdover_enable) ==
		$past(ctrl[CTRL_HOLD_EN_HI] && ctrl[CTRL_HOLD_EN_LO]))
		else $error("holdover enable not from both bits");

	a_ext_select: assert property (@(posedge pclk) disable iff (!presetn)
		ctrl[CTRL_EXT_HOLD] |=> !automatic_holdover_enable)
		else $error("automatic holdover on in external mode");

	a_status_read: assert property (@(posedge pclk) disable iff (!presetn)
		(setup && !pwrite && paddr == ADDR_STATUS && !ctrl[CTRL_RB_DIS]) |=>
		pready && prdata == {25'h0, $past(live_status)})
		else $error("status read not live");

	a_status_rb_off: assert property (@(posedge pclk) disable iff (!presetn)
		(setup && !pwrite && paddr == ADDR_STATUS && ctrl[CTRL_RB_DIS]) |=>
		prdata == 32'h0000_0000)
		else $error("status readback while disabled");

	a_status_wr_ign: assert property (@(posedge pclk) disable iff (!presetn)
		(done_wr && paddr == ADDR_STATUS) |=> $stable(ctrl) && $stable(imask))
		else $error("status write changed state");

	a_ctrl_write: assert property (@(posedge pclk) disable iff (!presetn)
		(done_wr && paddr == ADDR_CTRL) |=> ctrl == $past(pwdata[CTRL_W-1:0]))
		else $error("control write lost");

	a_ctrl_hold: assert property (@(posedge pclk) disable iff (!presetn)
		!(done_wr && paddr == ADDR_CTRL) |=> $stable(ctrl))
		else $error("control changed without write");

	a_status_pin: assert property (@(posedge pclk) disable iff (!presetn)
		(status_pin_select == PIN_SEL_COMP) |=>
		status_pin_comp_valid && status_pin_comp_n == !$past(comp_result))
		else $error("status pin comparator wrong");

	a_reference_monitor_pin_pin: assert property (@(posedge pclk) disable iff (!presetn)
		(reference_monitor_select == PIN_SEL_COMP) |=>
		reference_monitor_comp_valid && reference_monitor_comp_n == !$past(comp_result))
		else $error("monitor pin comparator wrong");

	a_lock_lost_irq: assert property (@(posedge pclk) disable iff (!presetn)
		($fell(digital_lock_flag) && imask[IRQ_LOCK_LOST]) |=> ##1 irq)
		else $error("lock loss did not interrupt");

endmodule

// ---- verif/test_holdover_and_pll_status_regs.sv ----
`timescale 1ns/1ns
module test_holdover_and_pll_status_regs;
	import hps_pkg::*;

	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [6:0]  st;
	logic        lip;
	logic [4:0]  sps;
	logic [4:0]  rms;
	logic        comparator_enable;
	logic        lock_qualifier;
	logic        automatic_holdover_enable;
	logic        external_holdover_enable;
	logic        sp_n;
	logic        sp_v;
	logic        rm_n;
	logic        rm_v;
	logic        irq;
	logic [31:0] rd;
	logic        er;
	logic [3:0]  b;
	int          errors;
	int          samples_checked;

	hps_regs u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .cal_finished(st[6]), .holdover_active(st[5]),
		.secondary_ref_selected(st[4]), .vco_above_threshold(st[3]),
		.secondary_ref_above(st[2]), .primary_ref_above(st[1]), .digital_lock_flag(st[0]),
		.lock_indicator_pin(lip), .status_pin_select(sps), .reference_monitor_select(rms),
		.comparator_enable(comparator_enable), .lock_qualifier(lock_qualifier),
		.automatic_holdover_enable(automatic_holdover_enable),
		.external_holdover_enable(external_holdover_enable), .status_pin_comp_n(sp_n),
		.status_pin_comp_valid(sp_v), .reference_monitor_comp_n(rm_n),
		.reference_monitor_comp_valid(rm_v), .irq(irq));

	// Free running bus clock, 40 ns period
	always #20 pclk = ~pclk;

	task chk_word(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			errors++;
			$display("BAD %0t word got %h expected %h", $time, got, exp);
		end
	endtask

	task chk_bit(input logic got, input logic exp);
		samples_checked++;
		if (got !== exp)
		begin
			errors++;
			$display("BAD %0t bit got %b expected %b", $time, got, exp);
		end
	endtask

	// One APB transfer; answer taken at the edge where pready is seen high
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 50);
		if (n >= 50)
			chk_bit(1'b0, 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task test_done;
		$display("errors %0d samples_checked %0d", errors, samples_checked);
		if (errors == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// Hang guard, far beyond the few hundred cycles the tests need
	initial
	begin
		#800000;
		errors++;
		test_done;
	end

	// Main sequence
	initial
	begin
		pclk = 1'b0;
		presetn = 1'b0;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		st = '0;
		lip = 1'b0;
		sps = 5'h00;
		rms = 5'h00;
		errors = 0;
		samples_checked = 0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		chk_bit(lock_qualifier, 1'b1);
		chk_bit(automatic_holdover_enable, 1'b0);
		apb(1'b0, ADDR_CTRL, 32'h0);
		chk_word(rd, 32'h0);
		// Every combination of the four low control bits (CTRL_RB_DIS held 0), pin low and high; upper bits must not stick
		for (int i = 0; i < 16; i++)
		begin
			b = i[3:0];
			apb(1'b1, ADDR_CTRL, {28'hFFFFFFE, b});
			for (int p = 0; p < 2; p++)
			begin
				lip <= p[0];
				repeat (3) @(posedge pclk);
				chk_bit(comparator_enable, b[3]);
				chk_bit(lock_qualifier, b[3] ? p[0] : 1'b1);
				chk_bit(automatic_holdover_enable, b[2] & b[0] & ~b[1]);
				chk_bit(external_holdover_enable, b[2] & b[0] & b[1]);
				chk_bit(sp_n, ~(b[3] & p[0]));
				chk_bit(rm_n, ~(b[3] & p[0]));
			end
			apb(1'b0, ADDR_CTRL, 32'h0);
			chk_word(rd, {28'h0, b});
		end
		// Walking one across the live status inputs
		for (int i = 0; i < 7; i++)
		begin
			st <= 7'h01 << i;
			repeat (2) @(posedge pclk);
			apb(1'b0, ADDR_STATUS, 32'h0);
			chk_word(rd, 32'h1 << i);
		end
		st <= 7'h7F;
		apb(1'b1, ADDR_STATUS, 32'h0);
		apb(1'b0, ADDR_STATUS, 32'h0);
		chk_word(rd, 32'h7F);
		apb(1'b1, ADDR_CTRL, 32'h10);
		apb(1'b0, ADDR_STATUS, 32'h0);
		chk_word(rd, 32'h0);
		apb(1'b1, ADDR_CTRL, 32'h0);
		apb(1'b0, ADDR_STATUS, 32'h0);
		chk_word(rd, 32'h7F);
		// Pin multiplexer codes around the comparator code
		for (int i = 0; i < 3; i++)
		begin
			sps <= (i == 0) ? 5'h1F : (i == 1) ? 5'h1E : 5'h0F;
			rms <= (i == 0) ? 5'h1F : (i == 1) ? 5'h0F : 5'h1E;
			repeat (3) @(posedge pclk);
			chk_bit(sp_v, i == 0);
			chk_bit(rm_v, i == 0);
		end
		// Unmapped address answers with an error and no data
		apb(1'b1, 8'h40, 32'hFF);
		chk_bit(er, 1'b1);
		apb(1'b0, 8'h40, 32'h0);
		chk_word(rd, 32'h0);
		chk_bit(er, 1'b1);
		// Interrupt: clear history, raise, clear, then masked pending event
		st <= 7'h00;
		repeat (3) @(posedge pclk);
		chk_bit(automatic_holdover_enable, 1'b0);
		apb(1'b1, ADDR_ISTAT, 32'hF);
		apb(1'b1, ADDR_IMASK, 32'h1);
		repeat (2) @(posedge pclk);
		chk_bit(irq, 1'b0);
		st[6] <= 1'b1;
		repeat (3) @(posedge pclk);
		chk_bit(irq, 1'b1);
		apb(1'b0, ADDR_ISTAT, 32'h0);
		chk_word(rd, 32'h1);
		apb(1'b1, ADDR_ISTAT, 32'h1);
		repeat (2) @(posedge pclk);
		chk_bit(irq, 1'b0);
		st[0] <= 1'b1;
		repeat (2) @(posedge pclk);
		st[0] <= 1'b0;
		repeat (3) @(posedge pclk);
		chk_bit(irq, 1'b0);
		apb(1'b0, ADDR_ISTAT, 32'h0);
		chk_word(rd, 32'h4);
		apb(1'b1, ADDR_IMASK, 32'h4);
		repeat (3) @(posedge pclk);
		chk_bit(irq, 1'b1);
		// Lock loss with its mask open raises the interrupt directly
		apb(1'b1, ADDR_ISTAT, 32'h4);
		repeat (2) @(posedge pclk);
		chk_bit(irq, 1'b0);
		st[0] <= 1'b1;
		repeat (2) @(posedge pclk);
		st[0] <= 1'b0;
		repeat (3) @(posedge pclk);
		chk_bit(irq, 1'b1);
		// Second reset in mid-run restores defaults
		apb(1'b1, ADDR_CTRL, 32'hF);
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, ADDR_CTRL, 32'h0);
		chk_word(rd, 32'h0);
		// Calibration input still high: no false event after reset
		apb(1'b0, ADDR_ISTAT, 32'h0);
		chk_word(rd, 32'h0);
		chk_bit(irq, 1'b0);
		test_done;
	end

endmodule
